// [hw/fcapcp_port.sv]
`timescale 1ns/1ps
`default_nettype none
module fcapcp_port
	import fcapcp_pkg::*;
#(
	parameter int N_MUL  = FCAPCP_N_DEFAULT,
	parameter int SAMPLE = FCAPCP_SAMPLE_DEF
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic        cs_n_in,
	input  wire logic        wr_n_in,
	input  wire logic        rd_n_in,
	input  wire logic [7:0]  command_bus_in,
	output logic      [7:0]  command_bus_out,
	output logic      [7:0]  command_bus_oe_out,
	output logic      [17:0] rom_addr_out,
	input  wire logic [7:0]  rom_data_in,
	output logic      [3:0]  busy_out,
	output logic      [3:0]  sound_out,
	output logic      [15:0] att_out,
	output logic      [15:0] nibble_out,
	output logic      [3:0]  nibble_valid_out
);
	localparam int BUSY_CYC  = FCAPCP_BUSY_MUL * N_MUL;
	localparam int SOUND_CYC = FCAPCP_SOUND_MUL * N_MUL;

	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA} fcapcp_fetch_e;

	////////////////////////////////////////////////////////////////
	logic        wr_n_q;
	logic        have_first;
	logic [6:0]  phrase;
	logic [15:0] cnt [4];
	logic [3:0]  pending;
	logic [3:0]  sus_req;
	logic [8:0]  sample_cnt;
	wire         wr_rise   = !wr_n_q && wr_n_in && !cs_n_in;
	wire         is_first  = command_bus_in[FCAPCP_CMD_BIT];
	wire         is_sus    = !is_first && !have_first;
	wire  [3:0]  sel       = command_bus_in[FCAPCP_SEL_LSB +: 4];
	wire  [3:0]  sus_mask  = command_bus_in[FCAPCP_SUS_LSB +: 4];
	wire         start_ok  = wr_rise && have_first && (phrase != 7'h00);
	wire  [3:0]  att_sat   = (command_bus_in[3:0] > FCAPCP_ATT_MAX) ?
		FCAPCP_ATT_MAX : command_bus_in[3:0];
	wire         sample_pt = (sample_cnt == 9'(SAMPLE - 1));
	wire         reading   = !cs_n_in && !rd_n_in;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			wr_n_q <= 1'b1;
			have_first <= 1'b0;
			phrase <= 7'h00;
			sample_cnt <= 9'h000;
			sus_req <= 4'h0;
		end else begin
			wr_n_q <= wr_n_in;
			sample_cnt <= sample_pt ? 9'h000 : sample_cnt + 9'h001;
			if (wr_rise && !have_first && is_first) begin
				have_first <= 1'b1;
				phrase <= command_bus_in[6:0];
			end else if (wr_rise) begin
				have_first <= 1'b0;
			end
			if (wr_rise && is_sus) begin
				sus_req <= sus_req | sus_mask;
			end else if (sample_pt) begin
				sus_req <= 4'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// One start counter per channel; any order of starts works
	genvar g;
	for (g = 0; g < FCAPCP_CHANNELS; g++) begin : g_ch
		wire go   = start_ok && sel[g];
		wire halt = wr_rise && is_sus && sus_mask[g];
		always_ff @(posedge clk_sys_in) begin
			if (rst_in) begin
				cnt[g] <= 16'h0000;
				pending[g] <= 1'b0;
				busy_out[g] <= 1'b0;
				sound_out[g] <= 1'b0;
				att_out[g*4 +: 4] <= 4'h0;
			end else if (halt) begin
				pending[g] <= 1'b0;
				busy_out[g] <= 1'b0;
				sound_out[g] <= 1'b0;
			end else if (go) begin
				pending[g] <= 1'b1;
				cnt[g] <= 16'h0000;
				att_out[g*4 +: 4] <= att_sat;
			end else if (pending[g]) begin
				cnt[g] <= cnt[g] + 16'h0001;
				if (cnt[g] == 16'(BUSY_CYC - 1)) busy_out[g] <= 1'b1;
				if (cnt[g] == 16'(SOUND_CYC - 1)) begin
					sound_out[g] <= 1'b1;
					pending[g] <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Single shared fetcher follows the latest start only
	fcapcp_fetch_e state;
	logic [2:0]  idx;
	logic [17:0] ptr;
	logic [17:0] end_addr;
	logic [1:0]  chan;
	logic        low_half;
	wire  [17:0] tbl = {8'h00, phrase, 3'h0};
	wire  [1:0]  sel_chan = sel[3] ? 2'h3 : sel[2] ? 2'h2 : sel[1] ? 2'h1 : 2'h0;
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state <= ST_IDLE;
			idx <= 3'h0;
			ptr <= 18'h00000;
			end_addr <= 18'h00000;
			chan <= 2'h0;
			low_half <= 1'b0;
			rom_addr_out <= 18'h00000;
			nibble_out <= 16'h0000;
			nibble_valid_out <= 4'h0;
		end else begin
			nibble_valid_out <= 4'h0;
			unique case (state)
				ST_IDLE: if (start_ok) begin
					state <= ST_ADDR;
					idx <= 3'h0;
					rom_addr_out <= tbl;
					chan <= sel[3] ? 2'h3 : sel[2] ? 2'h2 : sel[1] ? 2'h1 : 2'h0;
				end
				ST_ADDR: begin
					unique case (idx)
						3'h0: ptr[17:16] <= rom_data_in[1:0];
						3'h1: ptr[15:8] <= rom_data_in;
						3'h2: ptr[7:0] <= rom_data_in;
						3'h3: end_addr[17:16] <= rom_data_in[1:0];
						3'h4: end_addr[15:8] <= rom_data_in;
						default: end_addr[7:0] <= rom_data_in;
					endcase
					idx <= idx + 3'h1;
					rom_addr_out <= rom_addr_out + 18'h00001;
					if (idx == 3'h5) begin
						state <= ST_DATA;
						low_half <= 1'b0;
					end
				end
				default: begin
					rom_addr_out <= ptr;
					if (!busy_out[chan] && !pending[chan]) begin
						state <= ST_IDLE;
					end else if (sample_pt && sound_out[chan]) begin
						nibble_out[chan*4 +: 4] <= low_half ? rom_data_in[3:0] :
							rom_data_in[7:4];
						nibble_valid_out[chan] <= 1'b1;
						low_half <= !low_half;
						if (low_half) begin
							if (ptr == end_addr) state <= ST_IDLE;
							ptr <= ptr + 18'h00001;
						end
					end
				end
			endcase
			// A later start takes the fetcher over; the older channel keeps busy and sound high but gets no more nibbles
			if (start_ok) begin
				state <= ST_ADDR;
				idx <= 3'h0;
				rom_addr_out <= tbl;
				chan <= sel_chan;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			command_bus_out <= 8'h00;
			command_bus_oe_out <= 8'h00;
		end else begin
			command_bus_out <= {4'h0, busy_out};
			command_bus_oe_out <= reading ? 8'h0f : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////
	// Some checks lean on the host keeping its spacing rules
	busy_timing_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		start_ok && sel == 4'h1 && !busy_out[0] ##1 (!wr_rise)[*8] |-> !busy_out[0])
		else $error("busy rose too early");
	suspend_stop_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		wr_rise && is_sus |=> ((busy_out | sound_out) & $past(sus_mask)) == 4'h0)
		else $error("suspend did not stop channel");
	read_drive_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		reading |=> command_bus_oe_out == 8'h0f)
		else $error("busy not driven on read");
	oe_release_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		!reading |=> command_bus_oe_out == 8'h00)
		else $error("bus still driven after read");
	zero_phrase_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		wr_rise && have_first && phrase == 7'h00 |=> (pending & ~$past(pending)) == 4'h0)
		else $error("phrase zero started");
	att_range_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		att_out[3:0] <= FCAPCP_ATT_MAX)
		else $error("attenuation out of range");
	stop_quiet_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		sus_req != 4'h0 |-> (sus_req & (busy_out | sound_out)) == 4'h0)
		else $error("suspended channel busy before next sample");
	sound_busy_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		(sound_out & ~busy_out) == 4'h0)
		else $error("sound without busy");
	nibble_gate_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		nibble_valid_out != 4'h0 |-> ($past(sound_out) & nibble_valid_out) != 4'h0)
		else $error("nibble handed to a silent channel");
endmodule
`default_nettype wire

// [common/fcapcp_pkg.sv]
package fcapcp_pkg;
	localparam int          FCAPCP_CHANNELS   = 4;
	localparam int          FCAPCP_N_DEFAULT  = 4;
	localparam int          FCAPCP_BUSY_MUL   = 15;
	localparam int          FCAPCP_SOUND_MUL  = 48;
	localparam int          FCAPCP_SAMPLE_DEF = 132;
	localparam logic [3:0]  FCAPCP_ATT_MAX    = 4'h8;
	localparam int          FCAPCP_CMD_BIT    = 7;
	localparam int          FCAPCP_SEL_LSB    = 4;
	localparam int          FCAPCP_SUS_LSB    = 3;
	localparam logic [17:0] FCAPCP_TABLE_STEP = 18'h00008;
endpackage

// [testbench/fcapcp_rom_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fcapcp_rom_model (
	input  wire logic [17:0] rom_addr_in,
	output logic      [7:0]  rom_data_out
);
	// Phrase p runs from 0x1_0p00 to 0x1_0p0f; data scrambled so nibbles vary
	logic [2:0] slot;
	assign slot = rom_addr_in[2:0];
	assign rom_data_out = (rom_addr_in[17:16] != 2'h0) ? (rom_addr_in[7:0] ^ 8'h5a) :
		(slot == 3'h0 || slot == 3'h3) ? 8'h01 :
		(slot == 3'h1 || slot == 3'h4) ? {1'b0, rom_addr_in[9:3]} :
		(slot == 3'h5) ? 8'h0f : 8'h00;
endmodule
`default_nettype wire

// [testbench/test_four_channel_adpcm_phrase_command_port.sv]
`timescale 1ns/1ps
`default_nettype none
module test_four_channel_adpcm_phrase_command_port import fcapcp_pkg::*;;
	localparam int SAMPLE    = 8;
	localparam int N_MUL     = 1;
	localparam int BUSY_CYC  = FCAPCP_BUSY_MUL * N_MUL;
	localparam int SOUND_CYC = FCAPCP_SOUND_MUL * N_MUL;
	logic        clk_sys_in, rst_in, cs_n, wr_n, rd_n;
	logic [7:0]  bus_in, bus_out, oe, rom_data;
	logic [17:0] rom_addr;
	logic [3:0]  busy, sound, nib_v;
	logic [15:0] att, nib;
	int          error_cnt = 0;
	int          samples_checked = 0;
	fcapcp_port #(.N_MUL(N_MUL), .SAMPLE(SAMPLE)) i_dut (.clk_sys_in(clk_sys_in),
		.rst_in(rst_in), .cs_n_in(cs_n), .wr_n_in(wr_n), .rd_n_in(rd_n),
		.command_bus_in(bus_in), .command_bus_out(bus_out), .command_bus_oe_out(oe),
		.rom_addr_out(rom_addr), .rom_data_in(rom_data), .busy_out(busy),
		.sound_out(sound), .att_out(att), .nibble_out(nib), .nibble_valid_out(nib_v));
	fcapcp_rom_model i_rom (.rom_addr_in(rom_addr), .rom_data_out(rom_data));
	////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask
	// Select held over the strobe rise and one cycle past it
	task automatic wr_byte(input logic [7:0] b);
		@(negedge clk_sys_in);
		cs_n = 1'b0;
		bus_in = b;
		wr_n = 1'b0;
		cyc(1);
		wr_n = 1'b1;
		cyc(1);
		cs_n = 1'b1;
	endtask
	task automatic read_busy(input logic [3:0] exp);
		@(negedge clk_sys_in);
		cs_n = 1'b0;
		rd_n = 1'b0;
		cyc(2);
		check({8'h00, bus_out}, {12'h000, exp});
		check({8'h00, oe}, 16'h000f);
		rd_n = 1'b1;
		cs_n = 1'b1;
	endtask
	// Waits for the next handed-over nibble; ROM byte is address low byte xor 5a
	task automatic wait_nib(input int c, input logic [3:0] exp);
		int n;
		n = 0;
		while (nib_v == 4'h0 && n < 4 * SAMPLE) begin
			cyc(1);
			n++;
		end
		check({12'h000, nib_v}, 16'(1 << c));
		check({12'h000, nib[c*4 +: 4]}, {12'h000, exp});
		cyc(1);
	endtask
	task automatic t_first_start;
		wr_byte(8'h85);
		cyc(20);
		check({12'h0, busy}, 16'h0);
		wr_byte(8'h83);
		cyc(BUSY_CYC - 1);
		check({12'h0, busy}, 16'h0);
		cyc(1);
		check({12'h0, busy}, 16'h8);
		cyc(SOUND_CYC - BUSY_CYC - 1);
		check({12'h0, sound}, 16'h0);
		cyc(1);
		check({12'h0, sound}, 16'h8);
		check(att, 16'h3000);
		wait_nib(3, 4'h5);
		check(rom_addr[15:0], 16'h0500);
		wait_nib(3, 4'ha);
	endtask
	task automatic t_second_start;
		cyc(30);
		wr_byte(8'h81);
		wr_byte(8'h1f);
		cyc(SOUND_CYC);
		check({12'h0, sound}, 16'h9);
		wait_nib(0, 4'h5);
		wait_nib(0, 4'ha);
		check(att, {4'h3, 8'h00, FCAPCP_ATT_MAX});
		read_busy(4'h9);
	endtask
	task automatic t_suspend;
		wr_byte(8'h4f);
		cyc(1);
		check({12'h0, busy}, 16'h0);
		check({12'h0, sound}, 16'h0);
		cyc(SAMPLE + 2);
		wr_byte(8'h80);
		wr_byte(8'h23);
		cyc(60);
		check({12'h0, busy}, 16'h0);
		read_busy(4'h0);
	endtask
	task automatic finish_test;
		$display("checks=%0d errors=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end
	// Tests need well under a thousand cycles
	initial begin
		#20us;
		error_cnt++;
		finish_test();
	end
	initial begin
		rst_in = 1'b1;
		cs_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		bus_in = 8'h00;
		cyc(10);
		rst_in = 1'b0;
		check({12'h0, busy}, 16'h0);
		t_first_start();
		t_second_start();
		t_suspend();
		finish_test();
	end
endmodule
`default_nettype wire
